// File: core/fifo_port_consts.vh
`ifndef FIFO_PORT_CONSTS_VH
`define FIFO_PORT_CONSTS_VH

// ----------------------------------------
// Data path shape
// ----------------------------------------
`define WORD_W 36
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define CNT_W 5
`define DEPTH_CNT 5'h10
`define HALF_CNT 5'h08

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define REG_AF_OFFSET 8'h00
`define REG_AE_OFFSET 8'h04
`define REG_PARITY 8'h08
`define REG_STATUS 8'h0c
`define REG_COUNTS 8'h10

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define OFFSET_RESET 8'h08
`define SENSE_ODD 1'b1
`define ST_AB_LSB 0
`define ST_BA_LSB 8
`define ST_PERR_A 16
`define ST_PERR_B 17

// ----------------------------------------
// Acknowledge throttle
// ----------------------------------------
`define PHASE_LAST 2'h2

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: core/fifo_port_ack_flow_and_parity.v
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`include "fifo_port_consts.vh"
`default_nettype none

// ----------------------------------------
// Word FIFO
// ----------------------------------------
module word_fifo #(
  parameter W = 36,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk_sys, // System clock
  input wire sys_rst, // Synchronous reset
  input wire in_valid, // Write request
  output wire in_ready, // Not full
  input wire [W-1:0] in_data, // Write word
  output wire out_valid, // Not empty
  input wire out_ready, // Read request
  output wire [W-1:0] out_data, // Head word
  output wire [AW:0] count // Words held
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] used;
  wire push;
  wire pop;

  // Handshakes; full and empty refuse
  assign in_ready = (used != D[AW:0]);
  assign out_valid = (used != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_ready & out_valid;
  assign out_data = mem[rd_ptr];
  assign count = used;

  // Storage
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill count
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      used <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        used <= used + 1'b1;
      end else if (pop && !push) begin
        used <= used - 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------
// Two-port flow control and parity
// ----------------------------------------
module fifo_port_ack_flow_and_parity (
  input wire clk_sys, // System clock
  input wire sys_rst, // Synchronous reset
  input wire pa_req, // Port A request
  input wire pa_en, // Port A enable
  input wire pa_rw, // Port A 1 write, 0 read
  input wire [35:0] pa_din, // Port A write word
  output reg [35:0] pa_dout, // Port A output register
  output reg pa_ack, // Port A acknowledge
  output reg pa_perr, // Port A parity flag
  input wire pb_req, // Port B request
  input wire pb_en, // Port B enable
  input wire pb_rw, // Port B 1 write, 0 read
  input wire [35:0] pb_din, // Port B write word
  output reg [35:0] pb_dout, // Port B output register
  output reg pb_ack, // Port B acknowledge
  output reg pb_perr, // Port B parity flag
  input wire [7:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write strobes
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [7:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready // Read data ready
);
  // Next fill count after this cycle's push and pop
  function [4:0] cnt_next;
    input [4:0] cnt;
    input push;
    input pop;
    begin
      cnt_next = cnt + {4'h0, push} - {4'h0, pop};
    end
  endfunction

  // Inside the almost region for the current direction
  function in_region;
    input rw;
    input [4:0] wcnt;
    input [4:0] rcnt;
    input [7:0] af;
    input [7:0] ae;
    reg [4:0] vac;
    begin
      vac = `DEPTH_CNT - wcnt;
      in_region = rw ? ({3'h0, vac} < af) : ({3'h0, rcnt} <= ae);
    end
  endfunction

  // Odd count of ones in any byte, sense bit included
  function par_err;
    input [35:0] w;
    input sense;
    begin
      par_err = (^w[8:0] ^ sense) | (^w[17:9] ^ sense) |
                (^w[26:18] ^ sense) | (^w[35:27] ^ sense);
    end
  endfunction

  // Five fullness flags: empty, almost empty, half, almost full, full
  function [4:0] flags;
    input [4:0] cnt;
    input [7:0] af;
    input [7:0] ae;
    reg [4:0] vac;
    begin
      vac = `DEPTH_CNT - cnt;
      flags = {cnt == `DEPTH_CNT, {3'h0, vac} < af, cnt >= `HALF_CNT,
               {3'h0, cnt} <= ae, cnt == 5'h00};
    end
  endfunction

  reg [7:0] af_off;
  reg [7:0] ae_off;
  reg sense;
  reg [4:0] ab_flags;
  reg [4:0] ba_flags;
  reg a_req_m;
  reg a_req_s;
  reg b_req_m;
  reg b_req_s;
  reg [1:0] a_phase;
  reg [1:0] b_phase;
  wire ab_in_ready;
  wire ab_out_valid;
  wire [35:0] ab_out_data;
  wire [4:0] ab_cnt;
  wire ba_in_ready;
  wire ba_out_valid;
  wire [35:0] ba_out_data;
  wire [4:0] ba_cnt;

  // ----------------------------------------
  // Port transfers
  // ----------------------------------------
  // act only when enabled
  wire a_go = a_req_s & pa_en;
  wire b_go = b_req_s & pb_en;
  wire a_wr = a_go & pa_rw;
  wire a_rd = a_go & ~pa_rw;
  wire b_wr = b_go & pb_rw;
  wire b_rd = b_go & ~pb_rw;
  wire ab_push = a_wr & ab_in_ready;
  wire ab_pop = b_rd & ab_out_valid;
  wire ba_push = b_wr & ba_in_ready;
  wire ba_pop = a_rd & ba_out_valid;
  wire [4:0] ab_next = cnt_next(ab_cnt, ab_push, ab_pop);
  wire [4:0] ba_next = cnt_next(ba_cnt, ba_push, ba_pop);
  wire a_reg = in_region(pa_rw, ab_next, ba_next, af_off, ae_off);
  wire b_reg = in_region(pb_rw, ba_next, ab_next, af_off, ae_off);

  // Port A to port B, then port B to port A
  // one word per cycle each way
  word_fifo #(
    .W(`WORD_W),
    .D(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo_ab (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(a_wr),
    .in_ready(ab_in_ready),
    .in_data(pa_din),
    .out_valid(ab_out_valid),
    .out_ready(b_rd),
    .out_data(ab_out_data),
    .count(ab_cnt)
  );

  word_fifo #(
    .W(`WORD_W),
    .D(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo_ba (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(b_wr),
    .in_ready(ba_in_ready),
    .in_data(pb_din),
    .out_valid(ba_out_valid),
    .out_ready(a_rd),
    .out_data(ba_out_data),
    .count(ba_cnt)
  );

  // Request resynchronisers
  // two-stage request sync
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      a_req_m <= 1'b0;
      a_req_s <= 1'b0;
      b_req_m <= 1'b0;
      b_req_s <= 1'b0;
    end else begin
      a_req_m <= pa_req;
      a_req_s <= a_req_m;
      b_req_m <= pb_req;
      b_req_s <= b_req_m;
    end
  end

  // Acknowledge and throttle phase
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pa_ack <= 1'b0;
      pb_ack <= 1'b0;
      a_phase <= 2'h0;
      b_phase <= 2'h0;
    end else begin
      a_phase <= (pa_req & a_reg & (a_phase != `PHASE_LAST)) ? a_phase + 2'h1 : 2'h0;
      b_phase <= (pb_req & b_reg & (b_phase != `PHASE_LAST)) ? b_phase + 2'h1 : 2'h0;
      pa_ack <= pa_req & (~a_reg | (a_phase == `PHASE_LAST));
      pb_ack <= pb_req & (~b_reg | (b_phase == `PHASE_LAST));
    end
  end

  // Output registers and parity flags
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pa_dout <= 36'h0;
      pb_dout <= 36'h0;
      pa_perr <= 1'b0;
      pb_perr <= 1'b0;
    end else begin
      if (ba_pop) begin
        pa_dout <= ba_out_data;
        pa_perr <= par_err(ba_out_data, sense);
      end else begin
        pa_perr <= par_err(pa_dout, sense);
      end
      if (ab_pop) begin
        pb_dout <= ab_out_data;
        pb_perr <= par_err(ab_out_data, sense);
      end else begin
        pb_perr <= par_err(pb_dout, sense);
      end
    end
  end

  // Fullness flags from both ports
  // no port timing assumed
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ab_flags <= 5'h01;
      ba_flags <= 5'h01;
    end else begin
      ab_flags <= flags(ab_next, af_off, ae_off);
      ba_flags <= flags(ba_next, af_off, ae_off);
    end
  end

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;

  // Write address and data, either order
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `REG_AF_OFFSET || aw_addr == `REG_AE_OFFSET ||
            aw_addr == `REG_PARITY) begin
          s_axi_bresp <= `RESP_OKAY;
        end else if (aw_addr == `REG_STATUS || aw_addr == `REG_COUNTS) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers
  // offsets reset to eight
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      af_off <= `OFFSET_RESET;
      ae_off <= `OFFSET_RESET;
      sense <= `SENSE_ODD;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == `REG_AF_OFFSET) begin
        af_off <= w_data[7:0];
      end else if (aw_addr == `REG_AE_OFFSET) begin
        ae_off <= w_data[7:0];
      end else if (aw_addr == `REG_PARITY) begin
        sense <= w_data[0];
      end
    end
  end

  // Read channel
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        if (s_axi_araddr == `REG_AF_OFFSET) begin
          s_axi_rdata <= {24'h0, af_off};
        end else if (s_axi_araddr == `REG_AE_OFFSET) begin
          s_axi_rdata <= {24'h0, ae_off};
        end else if (s_axi_araddr == `REG_PARITY) begin
          s_axi_rdata <= {31'h0, sense};
        end else if (s_axi_araddr == `REG_STATUS) begin
          s_axi_rdata <= {14'h0, pb_perr, pa_perr, 3'h0, ba_flags, 3'h0, ab_flags};
        end else if (s_axi_araddr == `REG_COUNTS) begin
          s_axi_rdata <= {19'h0, ba_cnt, 3'h0, ab_cnt};
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// File: verif/fifo_port_chk.sv
`default_nettype none
// ----------------------------------------
// Port and bus checker
// ----------------------------------------
module fifo_port_chk (
  input wire logic clk_sys, // Clock
  input wire logic sys_rst, // Reset
  input wire logic pa_req, // A request
  input wire logic pa_en, // A enable
  input wire logic pa_rw, // A direction
  input wire logic [35:0] pa_dout, // A word
  input wire logic pa_ack, // A ack
  input wire logic pa_perr, // A parity
  input wire logic pb_req, // B request
  input wire logic pb_ack, // B ack
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready // R ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Bus handshake steps
  sequence s_aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_ack_drop_a;
    !pa_req |=> !pa_ack;
  endproperty
  a_ack_drop_a: assert property (p_ack_drop_a) else $error("A ack held");
  property p_ack_drop_b;
    pb_ack |-> $past(pb_req);
  endproperty
  a_ack_drop_b: assert property (p_ack_drop_b) else $error("B ack held");
  property p_dout_cause;
    $changed(pa_dout) |-> $past(sys_rst) || ($past(pa_en) && !$past(pa_rw) && $past(pa_req, 3));
  endproperty
  a_dout_cause: assert property (p_dout_cause) else $error("A word loaded without read");
  property p_perr_cause;
    $changed(pa_perr) |-> $past(sys_rst) || $past(sys_rst, 2) || $changed(pa_dout)
      || $past(s_axi_wready) || $past(s_axi_wready, 2) || $past(s_axi_wready, 3);
  endproperty
  a_perr_cause: assert property (p_perr_cause) else $error("A parity moved alone");
  property p_wr_answer;
    s_aw_taken |-> ##[1:4] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("No write response");
  property p_rd_answer;
    s_ar_taken |-> ##[1:3] s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("No read data");
  property p_bvalid_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bvalid_drop: assert property (p_bvalid_drop) else $error("Response repeated");
  property p_rvalid_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rvalid_drop: assert property (p_rvalid_drop) else $error("Read data repeated");
endmodule

bind fifo_port_ack_flow_and_parity fifo_port_chk chk (.clk_sys, .sys_rst, .pa_req, .pa_en,
  .pa_rw, .pa_dout, .pa_ack, .pa_perr, .pb_req, .pb_ack, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// File: verif/port_proc.sv
`default_nettype none
// ----------------------------------------
// Port processor model
// ----------------------------------------
module port_proc (
  input wire logic clk_sys, // Clock
  input wire logic sys_rst, // Reset
  input wire logic go, // Hold request
  input wire logic wr, // Write when high
  input wire logic loop, // Enable from ack
  input wire logic bad, // One-bit-byte word
  input wire logic ack, // Ack seen
  output logic req, // Request
  output logic en, // Enable
  output logic rw, // Direction
  output logic [35:0] din // Word sent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic r1, r2;
  logic [7:0] n;
  assign req = go;
  assign rw = wr;
  assign en = loop ? ack : 1'b1;
  // odd-parity words; bad gives one-bit bytes
  assign din = bad ? 36'h008040201 : {4{~^n, n}};
  // Word counter per transfer edge
  always @(posedge clk_sys) begin
    r1 <= sys_rst ? 1'b0 : req;
    r2 <= sys_rst ? 1'b0 : r1;
    n <= sys_rst ? 8'h00 : n + {7'h00, r2 & en};
  end
endmodule
`default_nettype wire

// File: verif/testbench.sv
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
// ----------------------------------------
// Bench top
// ----------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d, x; logic [1:0] r;} row_t;
  logic clk_sys = 1'b0, sys_rst = 1'b1;
  logic go_a = 1'b0, wr_a = 1'b0, go_b = 1'b0, wr_b = 1'b0, loop_b = 1'b0, bad_b = 1'b0;
  logic pa_req, pa_en, pa_rw, pa_ack, pa_perr, pb_req, pb_en, pb_rw, pb_ack, pb_perr;
  logic [35:0] pa_din, pa_dout, pb_din, pb_dout;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf, acks, tail;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int failures = 0, checks_done = 0, n_ack = 0;
  row_t rows [15] = '{'{1'b0, 8'h00, 32'h0, 32'h8, 2'h0}, '{1'b0, 8'h04, 32'h0, 32'h8, 2'h0},
    '{1'b0, 8'h08, 32'h0, 32'h1, 2'h0}, '{1'b0, 8'h0c, 32'h0, 32'h30303, 2'h0},
    '{1'b0, 8'h10, 32'h0, 32'h0, 2'h0}, '{1'b0, 8'h14, 32'h0, 32'h0, 2'h2},
    '{1'b1, 8'h00, 32'hff, 32'h0, 2'h0}, '{1'b0, 8'h00, 32'h0, 32'hff, 2'h0},
    '{1'b1, 8'h00, 32'h8, 32'h0, 2'h0}, '{1'b1, 8'h04, 32'h5, 32'h0, 2'h0},
    '{1'b0, 8'h04, 32'h0, 32'h5, 2'h0}, '{1'b1, 8'h04, 32'h8, 32'h0, 2'h0},
    '{1'b1, 8'h0c, 32'h0, 32'h0, 2'h0}, '{1'b0, 8'h0c, 32'h0, 32'h30303, 2'h0},
    '{1'b1, 8'h14, 32'h0, 32'h0, 2'h2}};
  fifo_port_ack_flow_and_parity DUT (.clk_sys, .sys_rst, .pa_req, .pa_en, .pa_rw, .pa_din,
    .pa_dout, .pa_ack, .pa_perr, .pb_req, .pb_en, .pb_rw, .pb_din, .pb_dout, .pb_ack,
    .pb_perr, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  port_proc pa_proc (.clk_sys, .sys_rst, .go(go_a), .wr(wr_a), .loop(1'b0), .bad(1'b0),
    .ack(pa_ack), .req(pa_req), .en(pa_en), .rw(pa_rw), .din(pa_din));
  port_proc pb_proc (.clk_sys, .sys_rst, .go(go_b), .wr(wr_b), .loop(loop_b), .bad(bad_b),
    .ack(pb_ack), .req(pb_req), .en(pb_en), .rw(pb_rw), .din(pb_din));
  // Good parity word
  function automatic logic [35:0] mk(input logic [7:0] v);
    return {4{~^v, v}};
  endfunction
  // Bus write, held until each channel is taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Bus read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Verdict
  task automatic test_done;
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Clock
  initial forever #10 clk_sys = ~clk_sys;
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    test_done;
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, rr);
      else axi_rd(rows[i].a, rd, rr);
      `CHK("resp", rows[i].r, rr)
      if (!rows[i].wr) `CHK("reg data", rows[i].x, rd)
    end
    go_a <= 1'b1;
    wr_a <= 1'b1;
    acks = 4'h0;
    tail = 4'h0;
    for (int i = 1; i < 26; i++) begin
      @(posedge clk_sys);
      #1;
      if (i <= 5) acks += pa_ack;
      if (i >= 20) tail += pa_ack;
      if (i == 10 || i == 11) `CHK("ack edge", i == 10, pa_ack)
    end
    `CHK("ack run", 4'h5, acks)
    `CHK("ack throttle", 4'h2, tail)
    @(posedge clk_sys);
    go_a <= 1'b0;
    acks = 4'h0;
    repeat (3) begin
      @(posedge clk_sys);
      #1;
      acks += pa_ack;
    end
    `CHK("ack off", 4'h0, acks)
    axi_rd(8'h10, rd, rr);
    `CHK("count full", 32'h10, rd)
    axi_rd(8'h0c, rd, rr);
    `CHK("status full", 32'h3031c, rd)
    go_b <= 1'b1;
    loop_b <= 1'b1;
    repeat (40) begin
      @(posedge clk_sys);
      #1;
      n_ack += pb_ack;
    end
    `CHK("read acks", 19, n_ack)
    @(posedge clk_sys);
    loop_b <= 1'b0;
    repeat (20) @(posedge clk_sys);
    go_b <= 1'b0;
    axi_rd(8'h10, rd, rr);
    `CHK("count empty", 32'h0, rd)
    `CHK("last word", mk(8'h0f), pb_dout)
    `CHK("b parity", 1'b0, pb_perr)
    axi_wr(8'h08, 32'h0, rr);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("perr clear", 1'b0, pa_perr)
    @(posedge clk_sys);
    bad_b <= 1'b1;
    wr_b <= 1'b1;
    go_b <= 1'b1;
    @(posedge clk_sys);
    go_b <= 1'b0;
    repeat (6) @(posedge clk_sys);
    wr_a <= 1'b0;
    go_a <= 1'b1;
    @(posedge clk_sys);
    go_a <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    `CHK("perr set", 1'b1, pa_perr)
    `CHK("a word", 36'h008040201, pa_dout)
    repeat (10) @(posedge clk_sys);
    #1;
    `CHK("perr held", 1'b1, pa_perr)
    axi_wr(8'h08, 32'h1, rr);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("perr odd", 1'b0, pa_perr)
    axi_wr(8'h08, 32'h0, rr);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("perr even", 1'b1, pa_perr)
    // Mid-run reset restores sense and clears the A register
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    axi_rd(8'h08, rd, rr);
    `CHK("sense reset", 32'h1, rd)
    `CHK("a word reset", 36'h0, pa_dout)
    test_done;
  end
endmodule
`default_nettype wire
